// ===== design/acpd_regs.vh
// Opcode patterns, operation codes and timing constants for the decoder
`ifndef ACPD_REGS_VH
`define ACPD_REGS_VH

// ----------------------------------------------------------------
// Fixed instruction words
// ----------------------------------------------------------------
`define ACPD_W_RST_OTHERS 32'h03c82240
`define ACPD_W_FIND_CLR 32'h03f82240
`define ACPD_W_PG_HALT 32'h00008000
`define ACPD_W_PG_SKIP 32'h00008005
`define ACPD_W_PG_HALT_SKIP 32'h00008001

// ----------------------------------------------------------------
// Prefixes (compared against the top digits; ACPD_T_MVMASK against the low four digits)
// ----------------------------------------------------------------
`define ACPD_P_BR_UNC 12'h280
`define ACPD_P_BR 8'h28
`define ACPD_P_BAL 8'h2c
`define ACPD_P_LOOP1 12'h3c0
`define ACPD_P_LOOPN 12'h3d0
`define ACPD_P_LDLOOP1 8'h3e
`define ACPD_P_LDLOOPN 8'h3f
`define ACPD_P_SWAP 12'h30c
`define ACPD_P_MVMASK 8'h08
`define ACPD_P_MVMASK_IND 8'h09
`define ACPD_T_MVMASK 16'h0001
`define ACPD_P_PG_LDPTR 16'h4000
`define ACPD_P_PG_BR 16'h0004
`define ACPD_P_XF_LOCK 16'h3806
`define ACPD_P_XF_CUINT 20'h38010
`define ACPD_P_XF_SCINT 20'h38012
`define ACPD_P_XF_RESET 20'h38002

// ----------------------------------------------------------------
// Operation codes on the decoded output
// ----------------------------------------------------------------
`define ACPD_OP_NONE 5'h00
`define ACPD_OP_LDI 5'h01
`define ACPD_OP_MOVR 5'h02
`define ACPD_OP_BR 5'h03
`define ACPD_OP_BRC 5'h04
`define ACPD_OP_BAL 5'h05
`define ACPD_OP_LOOP1 5'h06
`define ACPD_OP_LOOPN 5'h07
`define ACPD_OP_LDLOOP1 5'h08
`define ACPD_OP_LDLOOPN 5'h09
`define ACPD_OP_SWAP 5'h0a
`define ACPD_OP_MVMASK 5'h0b
`define ACPD_OP_MVMASK_IND 5'h0c
`define ACPD_OP_RST_OTHERS 5'h0d
`define ACPD_OP_FIND_CLR 5'h0e
`define ACPD_OP_PG_MOVE 5'h0f
`define ACPD_OP_PG_LDPTR 5'h10
`define ACPD_OP_PG_MOVE_LD 5'h11
`define ACPD_OP_PG_BR 5'h12
`define ACPD_OP_PG_HALT 5'h13
`define ACPD_OP_PG_SKIP 5'h14
`define ACPD_OP_PG_HALT_SKIP 5'h15
`define ACPD_OP_XF_LOCK 5'h16
`define ACPD_OP_XF_CUINT 5'h17
`define ACPD_OP_XF_SCINT 5'h18
`define ACPD_OP_XF_RESET 5'h19

// ----------------------------------------------------------------
// Timing, in nanoseconds, and cycle period
// ----------------------------------------------------------------
`define ACPD_CLK_NS 8
`define ACPD_T_BASE_NS 200
`define ACPD_T_MOVE_NS 1300
`define ACPD_T_IDX_NS 400
`define ACPD_T_DPTR_NS 100
`define ACPD_T_ARRSRC_NS 25
`define ACPD_CYC(ns) (((ns) + `ACPD_CLK_NS - 1) / `ACPD_CLK_NS)

`endif

// ===== design/acpd_timer.v
// Execution-time down counter that holds while shared memory is busy
`timescale 1ns/100ps
`default_nettype none
module acpd_timer #(
    parameter W = 16
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_load,
    input wire [W-1:0] i_cycles,
    input wire i_hold,
    output reg o_busy,
    output reg o_done
);
    reg [W-1:0] cnt_q;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= {W{1'b0}};
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_load) begin
                cnt_q <= i_cycles;
                o_busy <= 1'b1;
            end else if (o_busy && !i_hold) begin
                if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    cnt_q <= {W{1'b0}};
                end else begin
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== design/acpd_decoder.v
// Instruction decoder for the associative control unit and program pager
`timescale 1ns/100ps
`default_nettype none
`include "acpd_regs.vh"

// Behaviour
// - 3rr0vvvv loads immediate into register rr
// - 3rr000dd copies register rr to dd
// - 280 branch always; 28c branch if condition
// - 2C branch-and-link, link register 0 to 7
// - 3C0 single, 3D0 multi instruction loop
// - 3E/3F load count minus one and loop
// - 30C swaps status word with memory
// - 08nn0001 move mask, 09ii0001 indirect
// - 03C82240 resets other responders, one array
// - 3F82240 finds first, clears others
// - Pager 8kkk move takes 1.3us times n+1
// - Pager 4000 loads write pointer; C moves+loads
// - Pager 0004 replaces fetch pointer
// - Pager halt, skip, halt-and-skip words
// - 3806 interlock number and state digit
// - 38010 control-unit interrupt with state digit
// - 38012 sequential-controller interrupt vector
// - 38002nn0 reset-and-clear selected target
// - Tag adds 0.4us index, 0.1us pointer
// - Array source adds 0.025us to load
// - Stall while other units hold memory
module acpd_decoder #(
    parameter TW = 16
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_valid,
    input wire [31:0] i_instr,
    input wire i_pager,
    input wire i_cond_met,
    input wire [19:0] i_return_addr,
    input wire i_tag_index,
    input wire i_tag_dptr,
    input wire i_array_src,
    input wire i_needs_mem,
    input wire i_seq_mem_busy,
    input wire i_pager_mem_busy,
    input wire i_pio_mem_busy,
    output reg o_ready,
    output reg o_op_valid,
    output reg [4:0] o_op,
    output reg [7:0] o_reg_dst,
    output reg [7:0] o_reg_src,
    output reg [19:0] o_addr,
    output reg [15:0] o_value,
    output reg [11:0] o_count,
    output reg [3:0] o_state_bits,
    output reg o_branch_taken,
    output reg o_reg_we,
    output reg [31:0] o_reg_wdata,
    output reg [15:0] o_pager_write_pointer,
    output reg [15:0] o_pager_fetch_pointer,
    output reg o_pager_halt,
    output reg o_pager_skip,
    output reg o_stall,
    output reg o_done
);
    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam [TW-1:0] C_BASE = `ACPD_CYC(`ACPD_T_BASE_NS);
    localparam [TW-1:0] C_MOVE = `ACPD_CYC(`ACPD_T_MOVE_NS);
    localparam [TW-1:0] C_IDX = `ACPD_CYC(`ACPD_T_IDX_NS);
    localparam [TW-1:0] C_DPTR = `ACPD_CYC(`ACPD_T_DPTR_NS);
    localparam [TW-1:0] C_ARR = `ACPD_CYC(`ACPD_T_ARRSRC_NS);

    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    // ------------------------------------------------------------
    // Memory-busy synchronisers
    // ------------------------------------------------------------
    reg [2:0] busy_s1_q;
    reg [2:0] busy_s2_q;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_s1_q <= 3'h0;
            busy_s2_q <= 3'h0;
        end else begin
            busy_s1_q <= {i_seq_mem_busy, i_pager_mem_busy, i_pio_mem_busy};
            busy_s2_q <= busy_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function [4:0] decode_op;
        input [31:0] w;
        input pg;
        begin
            decode_op = `ACPD_OP_NONE;
            if (pg) begin
                // Exact pager words first; 0004 shares the 000 prefix
                if (w == `ACPD_W_PG_HALT)
                    decode_op = `ACPD_OP_PG_HALT;
                else if (w == `ACPD_W_PG_SKIP)
                    decode_op = `ACPD_OP_PG_SKIP;
                else if (w == `ACPD_W_PG_HALT_SKIP)
                    decode_op = `ACPD_OP_PG_HALT_SKIP;
                else if (w[31:16] == `ACPD_P_PG_BR)
                    decode_op = `ACPD_OP_PG_BR;
                else if (w[31:16] == `ACPD_P_PG_LDPTR)
                    decode_op = `ACPD_OP_PG_LDPTR;
                else if (w[31:28] == 4'h8 && w[15:0] == 16'h0000)
                    decode_op = `ACPD_OP_PG_MOVE;
                else if (w[31:28] == 4'hc)
                    decode_op = `ACPD_OP_PG_MOVE_LD;
            end else begin
                if (w == `ACPD_W_RST_OTHERS)
                    decode_op = `ACPD_OP_RST_OTHERS;
                else if (w == `ACPD_W_FIND_CLR)
                    decode_op = `ACPD_OP_FIND_CLR;
                else if (w[31:12] == `ACPD_P_XF_CUINT)
                    decode_op = `ACPD_OP_XF_CUINT;
                else if (w[31:12] == `ACPD_P_XF_SCINT)
                    decode_op = `ACPD_OP_XF_SCINT;
                else if (w[31:12] == `ACPD_P_XF_RESET && w[3:0] == 4'h0)
                    decode_op = `ACPD_OP_XF_RESET;
                else if (w[31:16] == `ACPD_P_XF_LOCK)
                    decode_op = `ACPD_OP_XF_LOCK;
                else if (w[31:20] == `ACPD_P_SWAP)
                    decode_op = `ACPD_OP_SWAP;
                else if (w[31:20] == `ACPD_P_LOOP1)
                    decode_op = `ACPD_OP_LOOP1;
                else if (w[31:20] == `ACPD_P_LOOPN)
                    decode_op = `ACPD_OP_LOOPN;
                else if (w[31:24] == `ACPD_P_LDLOOP1)
                    decode_op = `ACPD_OP_LDLOOP1;
                else if (w[31:24] == `ACPD_P_LDLOOPN)
                    decode_op = `ACPD_OP_LDLOOPN;
                else if (w[31:20] == `ACPD_P_BR_UNC)
                    decode_op = `ACPD_OP_BR;
                else if (w[31:24] == `ACPD_P_BR)
                    decode_op = `ACPD_OP_BRC;
                else if (w[31:24] == `ACPD_P_BAL && w[23] == 1'b0)
                    decode_op = `ACPD_OP_BAL;
                else if (w[31:24] == `ACPD_P_MVMASK &&
                         w[15:0] == `ACPD_T_MVMASK)
                    decode_op = `ACPD_OP_MVMASK;
                else if (w[31:24] == `ACPD_P_MVMASK_IND &&
                         w[15:0] == `ACPD_T_MVMASK)
                    decode_op = `ACPD_OP_MVMASK_IND;
                else if (w[31:28] == 4'h3 && w[19:8] == 12'h000)
                    decode_op = `ACPD_OP_MOVR;
                else if (w[31:28] == 4'h3 && w[19:16] == 4'h0)
                    decode_op = `ACPD_OP_LDI;
            end
        end
    endfunction

    wire [4:0] op_d = decode_op(i_instr, i_pager);
    wire [11:0] move_n = i_instr[27:16];
    wire [TW-1:0] move_cyc = C_MOVE * ({{(TW-12){1'b0}}, move_n} +
                                       {{(TW-1){1'b0}}, 1'b1});
    wire is_move = (op_d == `ACPD_OP_PG_MOVE);
    wire [TW-1:0] tag_cyc = i_tag_index ? C_IDX :
                            (i_tag_dptr ? C_DPTR : {TW{1'b0}});
    wire [TW-1:0] arr_cyc = i_array_src ? C_ARR : {TW{1'b0}};
    wire [TW-1:0] exec_cyc = (is_move ? move_cyc : C_BASE) + tag_cyc +
                             arr_cyc;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    reg state_q;
    reg needs_mem_q;
    reg start_q;
    reg [TW-1:0] exec_cyc_q;
    wire timer_busy;
    wire timer_done;
    wire mem_held = needs_mem_q && (|busy_s2_q);
    wire take = (state_q == ST_IDLE) && i_valid;

    acpd_timer #(.W(TW)) u_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(start_q),
        .i_cycles(exec_cyc_q),
        .i_hold(mem_held),
        .o_busy(timer_busy),
        .o_done(timer_done)
    );

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            needs_mem_q <= 1'b0;
            start_q <= 1'b0;
            exec_cyc_q <= {TW{1'b0}};
            o_ready <= 1'b1;
            o_op_valid <= 1'b0;
            o_op <= `ACPD_OP_NONE;
            o_reg_dst <= 8'h00;
            o_reg_src <= 8'h00;
            o_addr <= 20'h00000;
            o_value <= 16'h0000;
            o_count <= 12'h000;
            o_state_bits <= 4'h0;
            o_branch_taken <= 1'b0;
            o_reg_we <= 1'b0;
            o_reg_wdata <= 32'h00000000;
            o_pager_write_pointer <= 16'h0000;
            o_pager_fetch_pointer <= 16'h0000;
            o_pager_halt <= 1'b0;
            o_pager_skip <= 1'b0;
            o_stall <= 1'b0;
            o_done <= 1'b0;
        end else begin
            start_q <= 1'b0;
            o_op_valid <= 1'b0;
            o_reg_we <= 1'b0;
            o_branch_taken <= 1'b0;
            o_pager_skip <= 1'b0;
            o_done <= timer_done;
            o_stall <= timer_busy && mem_held;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        state_q <= ST_EXEC;
                        o_ready <= 1'b0;
                        start_q <= 1'b1;
                        exec_cyc_q <= exec_cyc;
                        needs_mem_q <= i_needs_mem;
                        o_op_valid <= 1'b1;
                        o_op <= op_d;
                        o_reg_dst <= i_instr[27:20];
                        o_reg_src <= i_instr[27:20];
                        o_addr <= i_instr[19:0];
                        o_value <= i_instr[15:0];
                        o_count <= {4'h0, i_instr[23:16]};
                        o_state_bits <= i_instr[3:0];
                        case (op_d)
                            `ACPD_OP_LDI: begin
                                o_reg_we <= 1'b1;
                                o_reg_wdata <= {16'h0000, i_instr[15:0]};
                            end
                            `ACPD_OP_MOVR: begin
                                o_reg_dst <= i_instr[7:0];
                            end
                            `ACPD_OP_BR: o_branch_taken <= 1'b1;
                            `ACPD_OP_BRC: o_branch_taken <= i_cond_met;
                            `ACPD_OP_BAL: begin
                                o_branch_taken <= 1'b1;
                                o_reg_dst <= {5'h00, i_instr[22:20]};
                                o_reg_we <= 1'b1;
                                o_reg_wdata <= {12'h000, i_return_addr};
                            end
                            `ACPD_OP_LDLOOP1, `ACPD_OP_LDLOOPN: begin
                                o_addr <= {4'h0, i_instr[15:0]};
                            end
                            `ACPD_OP_MVMASK, `ACPD_OP_MVMASK_IND: begin
                                o_addr <= {12'h000, i_instr[23:16]};
                            end
                            `ACPD_OP_PG_MOVE: o_count <= move_n;
                            `ACPD_OP_PG_LDPTR: begin
                                o_pager_write_pointer <= i_instr[15:0];
                            end
                            `ACPD_OP_PG_MOVE_LD: begin
                                o_count <= move_n;
                                o_pager_write_pointer <= i_instr[15:0];
                            end
                            `ACPD_OP_PG_BR: begin
                                o_pager_fetch_pointer <= i_instr[15:0];
                            end
                            `ACPD_OP_PG_HALT: o_pager_halt <= 1'b1;
                            `ACPD_OP_PG_SKIP: o_pager_skip <= 1'b1;
                            `ACPD_OP_PG_HALT_SKIP: begin
                                o_pager_halt <= 1'b1;
                                o_pager_skip <= 1'b1;
                            end
                            `ACPD_OP_XF_LOCK: begin
                                o_addr <= {8'h00, i_instr[15:4]};
                            end
                            `ACPD_OP_XF_CUINT, `ACPD_OP_XF_SCINT: begin
                                o_addr <= {12'h000, i_instr[11:4]};
                            end
                            `ACPD_OP_XF_RESET: begin
                                o_addr <= {12'h000, i_instr[11:4]};
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_EXEC: begin
                    // Halt persists until the next accepted instruction
                    if (timer_done) begin
                        state_q <= ST_IDLE;
                        o_ready <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (take && op_d != `ACPD_OP_PG_HALT &&
                op_d != `ACPD_OP_PG_HALT_SKIP)
                o_pager_halt <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/acpd_decoder_sva.sv
// Assertion checker bound to the instruction decoder ports
`timescale 1ns/100ps
`default_nettype none
`include "acpd_regs.vh"
module acpd_decoder_sva (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic [31:0] i_instr,
    input wire logic i_pager,
    input wire logic i_cond_met,
    input wire logic [19:0] i_return_addr,
    input wire logic i_tag_index,
    input wire logic i_tag_dptr,
    input wire logic i_array_src,
    input wire logic i_needs_mem,
    input wire logic o_ready,
    input wire logic [4:0] o_op,
    input wire logic [7:0] o_reg_dst,
    input wire logic [19:0] o_addr,
    input wire logic o_branch_taken,
    input wire logic o_reg_we,
    input wire logic [31:0] o_reg_wdata,
    input wire logic o_pager_skip,
    input wire logic o_pager_halt,
    input wire logic [15:0] o_pager_fetch_pointer,
    input wire logic o_done
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic [31:0] w_q;
    logic [19:0] ra_q;
    logic cond_q;
    wire take = i_valid && o_ready;
    wire cu = take && !i_pager;
    wire pg = take && i_pager;
    wire quiet = !i_array_src && !i_needs_mem;
    // Register forms only: loop, exchange and external prefixes excluded
    wire rf = i_instr[31:28] == 4'h3 && i_instr[27:24] < 4'h8;
    wire ldi = cu && rf && i_instr[27:20] != 8'h0c &&
        i_instr[19:16] == 4'h0 && i_instr[15:8] != 8'h0;
    always @(posedge i_clk) begin
        w_q <= i_instr;
        ra_q <= i_return_addr;
        cond_q <= i_cond_met;
    end
    property p_ldi;
        ldi |=> o_op == `ACPD_OP_LDI && o_reg_we && o_reg_dst == w_q[27:20]
            && o_reg_wdata == {16'h0, w_q[15:0]};
    endproperty
    a_ldi: assert property (p_ldi) else $error("load immediate wrong");
    property p_brc;
        cu && i_instr[31:24] == 8'h28 |=> o_addr == w_q[19:0] &&
            o_branch_taken == (w_q[23:20] == 4'h0 || cond_q);
    endproperty
    a_brc: assert property (p_brc) else $error("branch wrong");
    property p_bal;
        cu && i_instr[31:24] == 8'h2c |=> (w_q[23] ? o_op == `ACPD_OP_NONE :
            (o_reg_we && o_reg_wdata == {12'h0, ra_q} &&
            o_reg_dst == {4'h0, w_q[23:20]}));
    endproperty
    a_bal: assert property (p_bal) else $error("link wrong");
    property p_fixed;
        cu && (i_instr == `ACPD_W_RST_OTHERS || i_instr == `ACPD_W_FIND_CLR)
            |=> o_op == (w_q[20] ? `ACPD_OP_FIND_CLR : `ACPD_OP_RST_OTHERS);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed word wrong");
    property p_fetch;
        pg && i_instr[31:16] == 16'h0004 |=>
            o_pager_fetch_pointer == w_q[15:0];
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch pointer wrong");
    property p_halt;
        pg && i_instr == `ACPD_W_PG_HALT_SKIP |=> o_pager_halt && o_pager_skip;
    endproperty
    a_halt: assert property (p_halt) else $error("halt skip wrong");
    property p_idx;
        ldi && i_tag_index && quiet |-> ##77 !o_done ##1 o_done;
    endproperty
    a_idx: assert property (p_idx) else $error("index time wrong");
    property p_move;
        pg && i_instr == 32'h80000000 && quiet && !i_tag_index && !i_tag_dptr
            |-> ##165 !o_done ##1 o_done;
    endproperty
    a_move: assert property (p_move) else $error("move time wrong");
endmodule
bind acpd_decoder acpd_decoder_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_valid(i_valid), .i_instr(i_instr), .i_pager(i_pager),
    .i_cond_met(i_cond_met), .i_return_addr(i_return_addr),
    .i_tag_index(i_tag_index), .i_tag_dptr(i_tag_dptr),
    .i_array_src(i_array_src), .i_needs_mem(i_needs_mem), .o_ready(o_ready),
    .o_op(o_op), .o_reg_dst(o_reg_dst), .o_addr(o_addr),
    .o_branch_taken(o_branch_taken), .o_reg_we(o_reg_we),
    .o_reg_wdata(o_reg_wdata), .o_pager_skip(o_pager_skip),
    .o_pager_halt(o_pager_halt),
    .o_pager_fetch_pointer(o_pager_fetch_pointer), .o_done(o_done));
`default_nettype wire

// ===== testbench/acpd_mem_model.sv
// Other memory users that may hold shared core for a while
`timescale 1ns/100ps
`default_nettype none
module acpd_mem_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [1:0] i_who,
    input wire logic [7:0] i_len,
    output logic o_seq_busy,
    output logic o_pager_busy,
    output logic o_pio_busy
);
    logic [7:0] left_q;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            left_q <= 8'h0;
        end else if (i_start) begin
            left_q <= i_len;
        end else if (left_q != 8'h0) begin
            left_q <= left_q - 8'h1;
        end
    end
    assign o_seq_busy = left_q != 8'h0 && i_who == 2'h0;
    assign o_pager_busy = left_q != 8'h0 && i_who == 2'h1;
    assign o_pio_busy = left_q != 8'h0 && i_who == 2'h2;
endmodule
`default_nettype wire

// ===== testbench/acpd_decoder_test.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/100ps
`default_nettype none
`include "acpd_regs.vh"
module acpd_decoder_test;
    localparam int LIMIT = 20000;
    localparam int B = 27;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_valid = 1'b0;
    logic i_pager = 1'b0;
    logic i_cond_met = 1'b0;
    logic [31:0] i_instr = 32'h0;
    logic [19:0] i_return_addr = 20'h0;
    logic [3:0] side = 4'h0;
    logic mem_start = 1'b0;
    logic [1:0] mem_who = 2'h0;
    logic [7:0] mem_len = 8'h0;
    wire seq_busy, pg_busy, pio_busy, o_ready, o_op_valid, o_branch_taken;
    wire o_reg_we, o_pager_halt, o_pager_skip, o_stall, o_done;
    wire [4:0] o_op;
    wire [7:0] o_reg_dst, o_reg_src;
    wire [19:0] o_addr;
    wire [15:0] o_wp, o_fp, o_value;
    wire [11:0] o_count;
    wire [3:0] o_state_bits;
    wire [31:0] o_reg_wdata;
    int fail_count = 0, checks_done = 0, cyc = 0, lat = 0, stalls = 0;
    acpd_decoder dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
        .i_instr(i_instr), .i_pager(i_pager), .i_cond_met(i_cond_met),
        .i_return_addr(i_return_addr), .i_tag_index(side[0]),
        .i_tag_dptr(side[1]), .i_array_src(side[2]), .i_needs_mem(side[3]),
        .i_seq_mem_busy(seq_busy), .i_pager_mem_busy(pg_busy),
        .i_pio_mem_busy(pio_busy), .o_ready(o_ready), .o_op_valid(o_op_valid),
        .o_op(o_op), .o_reg_dst(o_reg_dst), .o_reg_src(o_reg_src),
        .o_addr(o_addr), .o_value(o_value), .o_count(o_count),
        .o_state_bits(o_state_bits), .o_branch_taken(o_branch_taken),
        .o_reg_we(o_reg_we), .o_reg_wdata(o_reg_wdata),
        .o_pager_write_pointer(o_wp), .o_pager_fetch_pointer(o_fp),
        .o_pager_halt(o_pager_halt), .o_pager_skip(o_pager_skip),
        .o_stall(o_stall), .o_done(o_done));
    acpd_mem_model mem (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(mem_start),
        .i_who(mem_who), .i_len(mem_len), .o_seq_busy(seq_busy),
        .o_pager_busy(pg_busy), .o_pio_busy(pio_busy));
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fail_count++;
            conclude();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Leaves the caller just after the first result edge
    task automatic run(input logic [31:0] w, input logic pg,
        input logic [3:0] s);
        while (o_ready !== 1'b1) begin
            @(posedge i_clk);
            #1;
        end
        @(posedge i_clk);
        i_instr <= w;
        i_pager <= pg;
        side <= s;
        i_valid <= 1'b1;
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
    endtask
    task automatic dec(input logic [31:0] w, input logic pg,
        input logic [4:0] op, input logic [19:0] a);
        run(w, pg, 4'h0);
        chk(o_op_valid, 1'b1);
        chk(o_op, op);
        chk(o_addr, a);
    endtask
    // Busy from the partner is requested a few cycles into execution
    task automatic tm(input logic [31:0] w, input logic pg,
        input logic [3:0] s, input int exp);
        run(w, pg, s);
        lat = 0;
        stalls = 0;
        while (o_done !== 1'b1) begin
            @(posedge i_clk);
            mem_start <= (lat == 4);
            #1;
            lat++;
            if (o_stall === 1'b1) stalls++;
        end
        chk(lat, exp);
    endtask
    task automatic t_ctrl();
        dec(32'h3120abcd, 1'b0, `ACPD_OP_LDI, 20'h0abcd);
        chk(o_reg_we, 1'b1);
        chk(o_reg_wdata, 32'h0000abcd);
        chk(o_value, 16'habcd);
        dec(32'h31200034, 1'b0, `ACPD_OP_MOVR, 20'h00034);
        chk({o_reg_src, o_reg_dst}, 16'h1234);
        dec(32'h28012345, 1'b0, `ACPD_OP_BR, 20'h12345);
        chk(o_branch_taken, 1'b1);
        for (int c = 0; c < 2; c++) begin
            @(posedge i_clk);
            i_cond_met <= c[0];
            dec(32'h283fedcb, 1'b0, `ACPD_OP_BRC, 20'hfedcb);
            chk(o_branch_taken, c[0]);
        end
        @(posedge i_clk);
        i_return_addr <= 20'h13579;
        dec(32'h2c7abcde, 1'b0, `ACPD_OP_BAL, 20'habcde);
        chk(o_reg_we, 1'b1);
        chk(o_reg_dst, 8'h07);
        chk(o_reg_wdata, 32'h00013579);
        run(32'h2c8abcde, 1'b0, 4'h0);
        chk(o_op, `ACPD_OP_NONE);
    endtask
    task automatic t_decode();
        dec(32'h3c012345, 1'b0, `ACPD_OP_LOOP1, 20'h12345);
        dec(32'h3d0abcde, 1'b0, `ACPD_OP_LOOPN, 20'habcde);
        dec(32'h3e07abcd, 1'b0, `ACPD_OP_LDLOOP1, 20'h0abcd);
        chk(o_count, 12'h007);
        dec(32'h3f11beef, 1'b0, `ACPD_OP_LDLOOPN, 20'h0beef);
        dec(32'h30c54321, 1'b0, `ACPD_OP_SWAP, 20'h54321);
        dec(32'h08420001, 1'b0, `ACPD_OP_MVMASK, 20'h00042);
        dec(32'h09130001, 1'b0, `ACPD_OP_MVMASK_IND, 20'h00013);
        dec(32'h03c82240, 1'b0, `ACPD_OP_RST_OTHERS, 20'h82240);
        dec(32'h03f82240, 1'b0, `ACPD_OP_FIND_CLR, 20'h82240);
        dec(32'h3806abc5, 1'b0, `ACPD_OP_XF_LOCK, 20'h00abc);
        chk(o_state_bits, 4'h5);
        dec(32'h3801012a, 1'b0, `ACPD_OP_XF_CUINT, 20'h00012);
        dec(32'h3801234b, 1'b0, `ACPD_OP_XF_SCINT, 20'h00034);
        dec(32'h38002560, 1'b0, `ACPD_OP_XF_RESET, 20'h00056);
        dec(32'h00008000, 1'b1, `ACPD_OP_PG_HALT, 20'h08000);
        chk(o_pager_halt, 1'b1);
        dec(32'h40001234, 1'b1, `ACPD_OP_PG_LDPTR, 20'h01234);
        chk({o_pager_halt, o_wp}, 17'h01234);
        dec(32'hc0035678, 1'b1, `ACPD_OP_PG_MOVE_LD, 20'h35678);
        dec(32'h00049abc, 1'b1, `ACPD_OP_PG_BR, 20'h49abc);
        chk(o_fp, 16'h9abc);
        dec(32'h00008005, 1'b1, `ACPD_OP_PG_SKIP, 20'h08005);
        chk(o_pager_skip, 1'b1);
        dec(32'h00008001, 1'b1, `ACPD_OP_PG_HALT_SKIP, 20'h08001);
    endtask
    task automatic t_timing();
        tm(32'h3120abcd, 1'b0, 4'h1, B + 50);
        tm(32'h3120abcd, 1'b0, 4'h2, B + 13);
        tm(32'h3120abcd, 1'b0, 4'h3, B + 50);
        tm(32'h3120abcd, 1'b0, 4'h4, B + 4);
        tm(32'h80000000, 1'b1, 4'h0, 163 + 2);
        tm(32'h80020000, 1'b1, 4'h0, 163 * 3 + 2);
    endtask
    task automatic t_stall();
        mem_len = 8'd12;
        for (int k = 0; k < 3; k++) begin
            mem_who = k[1:0];
            tm(32'h3120abcd, 1'b0, 4'h8, B + 12);
            chk(stalls, 12);
        end
        tm(32'h3120abcd, 1'b0, 4'h0, B);
        chk(stalls, 0);
        mem_len = 8'd0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        #1;
        chk({o_ready, o_op_valid, o_done, o_pager_halt, o_op}, 9'h100);
        t_ctrl();
        t_decode();
        t_timing();
        t_stall();
        conclude();
    end
endmodule
`default_nettype wire
